//--- verilog/crs_pkg.sv
// package of constants, types and register map for the core register state
package crs_pkg;

  // ****************************************
  // register bus map (byte addresses)
  // ****************************************
  localparam logic [7:0]  OFS_ACC       = 8'h00;
  localparam logic [7:0]  OFS_PTR       = 8'h04;
  localparam logic [7:0]  OFS_SP        = 8'h08;
  localparam logic [7:0]  OFS_PC        = 8'h0c;
  localparam logic [7:0]  OFS_FLAGS     = 8'h10;
  localparam logic [7:0]  OFS_STATUS    = 8'h14;

  // ****************************************
  // reset values, vectors and flag positions
  // ****************************************
  localparam logic [15:0] SP_RESET      = 16'h00ff;
  localparam logic [7:0]  SP_LOW_RESET  = 8'hff;
  localparam logic [15:0] VEC_RESET     = 16'hfffe;
  localparam logic [15:0] VEC_BREAK     = 16'hfffc;
  localparam logic [15:0] VEC_BREAK_MON = 16'hfefc;
  localparam logic [7:0]  FLAGS_ONES    = 8'h60;
  localparam logic [7:0]  FLAGS_RESET   = 8'h68;
  localparam int          BIT_C         = 0;
  localparam int          BIT_Z         = 1;
  localparam int          BIT_N         = 2;
  localparam int          BIT_I         = 3;
  localparam int          BIT_H         = 4;
  localparam int          BIT_V         = 7;
  // opcode value is arbitrary, kept apart from the instruction register reset
  localparam logic [7:0]  SWI_OPCODE    = 8'h5c;

  // ****************************************
  // sequencing counts
  // ****************************************
  localparam int          STAB_CYCLES   = 4096;
  localparam logic [11:0] STAB_LOAD     = 12'(STAB_CYCLES - 1);
  localparam logic [2:0]  STK_FIRST     = 3'd0;
  localparam logic [2:0]  STK_LAST      = 3'd4;
  localparam logic [2:0]  STK_HIGH      = 3'd5;

  // ****************************************
  // types
  // ****************************************
  typedef enum logic [3:0] {
    OP_NOP, OP_LOAD_ACC, OP_LOAD_HIGH, OP_LOAD_LOW, OP_ALU, OP_CARRY_LOAD,
    OP_STACK_RESET, OP_PUSH_HIGH, OP_PULL_HIGH, OP_PC_INC, OP_PC_LOAD,
    OP_CLEAR_MASK, OP_SET_MASK, OP_WAIT, OP_STOP, OP_RTI
  } crs_op_kind_type;

  typedef enum logic [2:0] {
    ALU_ADD, ALU_ADC, ALU_SUB, ALU_AND, ALU_ORA, ALU_EOR, ALU_SHL, ALU_SHR
  } crs_alu_kind_type;

  typedef enum logic [1:0] {
    BASE_NONE, BASE_PTR, BASE_SP
  } crs_base_type;

  typedef struct packed {
    crs_op_kind_type  kind;
    crs_alu_kind_type alu;
    crs_base_type     base;
    logic [7:0]       data8;
    logic [15:0]      data16;
  } crs_op_type;

  typedef struct packed {
    logic        req;
    logic        write;
    logic [15:0] addr;
    logic [7:0]  wdata;
  } crs_mem_req_type;

endpackage

//--- verilog/crs_alu.sv
// result and flag generation for accumulator operations
`timescale 1ns/10ps
module crs_alu (
  // operands
  input  wire crs_pkg::crs_alu_kind_type kind,
  input  wire logic [7:0]                a,
  input  wire logic [7:0]                m,
  input  wire logic                      cin,
  // result and flags
  output logic [7:0]                     res,
  output logic                           v,
  output logic                           h,
  output logic                           h_upd,
  output logic                           n,
  output logic                           z,
  output logic                           c
);
  import crs_pkg::*;

  logic [8:0] sum;
  logic [4:0] low;
  logic       cadd;

  always_comb begin
    sum   = 9'h000;
    low   = 5'h00;
    cadd  = cin & (kind == ALU_ADC);
    res   = a;
    v     = 1'b0;
    h     = 1'b0;
    h_upd = 1'b0;
    c     = cin;
    case (kind)
      ALU_ADD, ALU_ADC: begin
        sum   = {1'b0, a} + {1'b0, m} + {8'h00, cadd};
        low   = {1'b0, a[3:0]} + {1'b0, m[3:0]} + {4'h0, cadd};
        res   = sum[7:0];
        c     = sum[8];
        h     = low[4];
        h_upd = 1'b1;
        v     = (a[7] == m[7]) && (sum[7] != a[7]);
      end
      ALU_SUB: begin
        sum = {1'b0, a} - {1'b0, m};
        res = sum[7:0];
        c   = sum[8];
        v   = (a[7] != m[7]) && (sum[7] != a[7]);
      end
      ALU_AND: res = a & m;
      ALU_ORA: res = a | m;
      ALU_EOR: res = a ^ m;
      ALU_SHL: begin
        res = {a[6:0], 1'b0};
        c   = a[7];
        v   = a[7] ^ a[6];
      end
      ALU_SHR: begin
        res = {a[7], a[7:1]};
        c   = a[0];
        v   = a[7] ^ a[0];
      end
      default: res = a;
    endcase
    n = res[7];
    z = (res == 8'h00);
  end

endmodule

//--- verilog/crs_addr.sv
// operand address generation from pointer or stack base
`timescale 1ns/10ps
module crs_addr (
  // base and offset
  input  wire crs_pkg::crs_base_type base,
  input  wire logic [15:0]           ptr,
  input  wire logic [15:0]           sp,
  input  wire logic [15:0]           offset,
  // effective address
  output logic [15:0]                ea
);
  import crs_pkg::*;

  always_comb begin
    case (base)
      BASE_PTR: ea = ptr + offset;
      BASE_SP:  ea = sp + offset;
      default:  ea = offset;
    endcase
  end

endmodule

//--- verilog/crs_core_regs.sv
// architectural register state, interrupt entry, low power and break sequencing
//
// Decided for this implementation: the register addresses and register access over APB.
`timescale 1ns/10ps

module crs_core_regs (
  // clock and reset
  input  wire logic                     sys_clk,
  input  wire logic                     sys_rst,
  // operation port from the sequencer
  input  wire logic                     op_valid,
  input  wire crs_pkg::crs_op_type      op,
  input  wire logic                     instr_end,
  output logic                          op_ready,
  output logic                          core_run,
  output logic [15:0]                   ea,
  output logic [7:0]                    flags_out,
  output logic [7:0]                    instr_reg,
  // interrupt and break requests
  input  wire logic                     irq_req,
  input  wire logic [15:0]              irq_vector,
  input  wire logic                     brk_req,
  input  wire logic                     brk_match_last,
  input  wire logic                     monitor_mode,
  output logic                          brk_active,
  // memory port
  output crs_pkg::crs_mem_req_type      mem_out,
  input  wire logic                     mem_ack,
  input  wire logic [7:0]               mem_rdata,
  // apb slave
  input  wire logic                     psel,
  input  wire logic                     penable,
  input  wire logic                     pwrite,
  input  wire logic [7:0]               paddr,
  input  wire logic [31:0]              pwdata,
  output logic [31:0]                   prdata,
  output logic                          pready,
  output logic                          pslverr
);
  import crs_pkg::*;

  typedef enum logic [3:0] {
    ST_RUN, ST_PUSH, ST_PULL, ST_VEC_HI, ST_VEC_LO, ST_WAIT, ST_STOP, ST_STAB
  } crs_state_type;

  // ****************************************
  // state
  // ****************************************
  crs_state_type state;
  logic [2:0]    cnt;
  logic [11:0]   stab;
  logic [7:0]    acc;
  logic [15:0]   ptr;
  logic [15:0]   sp;
  logic [15:0]   pc;
  logic [7:0]    flags;
  logic [15:0]   vec_addr;
  logic [7:0]    alu_res;
  logic          alu_v;
  logic          alu_h;
  logic          alu_h_upd;
  logic          alu_n;
  logic          alu_z;
  logic          alu_c;
  logic [15:0]   next_ea;
  logic          take_brk;
  logic          take_irq;
  logic          op_fire;
  logic          mem_fin;
  logic          mem_state;
  logic [15:0]   next_addr;
  logic          next_write;
  logic [7:0]    next_wdata;
  logic          apb_wr;
  logic [31:0]   rd_val;
  logic          rd_hit;

  // ****************************************
  // datapath helpers
  // ****************************************
  crs_alu u_alu (
    .kind  (op.alu),
    .a     (acc),
    .m     (op.data8),
    .cin   (flags[BIT_C]),
    .res   (alu_res),
    .v     (alu_v),
    .h     (alu_h),
    .h_upd (alu_h_upd),
    .n     (alu_n),
    .z     (alu_z),
    .c     (alu_c)
  );

  crs_addr u_addr (
    .base   (op.base),
    .ptr    (ptr),
    .sp     (sp),
    .offset (op.data16),
    .ea     (next_ea)
  );

  // break is taken at the boundary, or at once on a last-cycle match
  assign take_brk = (state == ST_RUN) && brk_req && !brk_active
                    && (instr_end || brk_match_last);
  // maskable requests wait while the mask is set
  assign take_irq = (state == ST_RUN) && !take_brk && irq_req
                    && !flags[BIT_I] && instr_end;
  assign op_fire  = op_valid && (state == ST_RUN) && !take_brk && !take_irq;
  assign mem_fin  = mem_out.req && mem_ack;
  assign apb_wr   = psel && penable && pready && pwrite && !pslverr;

  // ****************************************
  // sequencer state
  // ****************************************
  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      state <= ST_VEC_HI;
      cnt   <= STK_FIRST;
      stab  <= 12'h000;
    end else begin
      case (state)
        ST_RUN: begin
          if (take_brk || take_irq) begin
            state <= ST_PUSH;
            cnt   <= STK_FIRST;
          end else if (op_fire) begin
            case (op.kind)
              OP_RTI: begin
                state <= ST_PULL;
                cnt   <= STK_FIRST;
              end
              OP_PUSH_HIGH: begin
                state <= ST_PUSH;
                cnt   <= STK_HIGH;
              end
              OP_PULL_HIGH: begin
                state <= ST_PULL;
                cnt   <= STK_HIGH;
              end
              OP_WAIT: state <= ST_WAIT;
              OP_STOP: state <= ST_STOP;
              default: state <= ST_RUN;
            endcase
          end
        end
        ST_PUSH: begin
          if (mem_fin) begin
            // the frame stops at five bytes, pointer high is left out
            if (cnt == STK_LAST) begin
              state <= ST_VEC_HI;
            end else if (cnt == STK_HIGH) begin
              state <= ST_RUN;
            end else begin
              cnt <= cnt + 3'd1;
            end
          end
        end
        ST_PULL: begin
          if (mem_fin) begin
            if (cnt >= STK_LAST) begin
              state <= ST_RUN;
            end else begin
              cnt <= cnt + 3'd1;
            end
          end
        end
        ST_VEC_HI: begin
          if (mem_fin) begin
            state <= ST_VEC_LO;
          end
        end
        ST_VEC_LO: begin
          if (mem_fin) begin
            state <= ST_RUN;
          end
        end
        ST_WAIT: begin
          if (irq_req) begin
            state <= ST_PUSH;
            cnt   <= STK_FIRST;
          end
        end
        ST_STOP: begin
          if (irq_req) begin
            state <= ST_STAB;
            stab  <= STAB_LOAD;
          end
        end
        ST_STAB: begin
          // core clock stays off until the oscillator has settled
          if (stab == 12'h000) begin
            state <= ST_PUSH;
            cnt   <= STK_FIRST;
          end else begin
            stab <= stab - 12'h001;
          end
        end
        default: state <= ST_RUN;
      endcase
    end
  end

  // ****************************************
  // memory requests
  // ****************************************
  always_comb begin
    next_addr  = vec_addr;
    next_write = 1'b0;
    next_wdata = 8'h00;
    mem_state  = 1'b1;
    case (state)
      ST_VEC_HI: next_addr = vec_addr;
      ST_VEC_LO: next_addr = vec_addr + 16'h0001;
      ST_PUSH: begin
        next_addr  = sp;
        next_write = 1'b1;
        case (cnt)
          3'd0:    next_wdata = pc[7:0];
          3'd1:    next_wdata = pc[15:8];
          3'd2:    next_wdata = ptr[7:0];
          3'd3:    next_wdata = acc;
          3'd4:    next_wdata = flags;
          default: next_wdata = ptr[15:8];
        endcase
      end
      ST_PULL: next_addr = sp + 16'h0001;
      default: mem_state = 1'b0;
    endcase
  end

  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      mem_out <= '0;
    end else if (mem_fin) begin
      mem_out.req <= 1'b0;
    end else if (!mem_out.req && mem_state) begin
      mem_out.req   <= 1'b1;
      mem_out.write <= next_write;
      mem_out.addr  <= next_addr;
      mem_out.wdata <= next_wdata;
    end
  end

  // ****************************************
  // accumulator
  // ****************************************
  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      acc <= 8'h00;
    end else if (op_fire && (op.kind == OP_LOAD_ACC)) begin
      acc <= op.data8;
    end else if (op_fire && (op.kind == OP_ALU)) begin
      acc <= alu_res;
    end else if ((state == ST_PULL) && mem_fin && (cnt == 3'd1)) begin
      acc <= mem_rdata;
    end else if (apb_wr && (paddr == OFS_ACC)) begin
      acc <= pwdata[7:0];
    end
  end

  // ****************************************
  // pointer pair
  // ****************************************
  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      ptr <= 16'h0000;
    end else if (op_fire && (op.kind == OP_LOAD_HIGH)) begin
      ptr[15:8] <= op.data8;
    end else if (op_fire && (op.kind == OP_LOAD_LOW)) begin
      ptr[7:0] <= op.data8;
    end else if ((state == ST_PULL) && mem_fin && (cnt == 3'd2)) begin
      ptr[7:0] <= mem_rdata;
    end else if ((state == ST_PULL) && mem_fin && (cnt == STK_HIGH)) begin
      ptr[15:8] <= mem_rdata;
    end else if (apb_wr && (paddr == OFS_PTR)) begin
      ptr <= pwdata[15:0];
    end
  end

  // ****************************************
  // stack pointer
  // ****************************************
  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      sp <= SP_RESET;
    end else if (op_fire && (op.kind == OP_STACK_RESET)) begin
      sp[7:0] <= SP_LOW_RESET;
    end else if ((state == ST_PUSH) && mem_fin) begin
      sp <= sp - 16'h0001;
    end else if ((state == ST_PULL) && mem_fin) begin
      sp <= sp + 16'h0001;
    end else if (apb_wr && (paddr == OFS_SP)) begin
      sp <= pwdata[15:0];
    end
  end

  // ****************************************
  // program counter
  // ****************************************
  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      pc <= 16'h0000;
    end else if ((state == ST_VEC_HI) && mem_fin) begin
      pc[15:8] <= mem_rdata;
    end else if ((state == ST_VEC_LO) && mem_fin) begin
      pc[7:0] <= mem_rdata;
    end else if ((state == ST_PULL) && mem_fin && (cnt == 3'd3)) begin
      pc[15:8] <= mem_rdata;
    end else if ((state == ST_PULL) && mem_fin && (cnt == STK_LAST)) begin
      pc[7:0] <= mem_rdata;
    end else if (op_fire && (op.kind == OP_PC_INC)) begin
      pc <= pc + 16'h0001;
    end else if (op_fire && (op.kind == OP_PC_LOAD)) begin
      pc <= op.data16;
    end else if (apb_wr && (paddr == OFS_PC)) begin
      pc <= pwdata[15:0];
    end
  end

  // ****************************************
  // condition flags
  // ****************************************
  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      flags <= FLAGS_RESET;
    end else if ((state == ST_PUSH) && mem_fin && (cnt == STK_LAST)) begin
      flags[BIT_I] <= 1'b1;
    end else if ((state == ST_PULL) && mem_fin && (cnt == STK_FIRST)) begin
      flags <= mem_rdata | FLAGS_ONES;
    end else if (op_fire) begin
      case (op.kind)
        OP_LOAD_ACC: begin
          flags[BIT_N] <= op.data8[7];
          flags[BIT_Z] <= (op.data8 == 8'h00);
          flags[BIT_V] <= 1'b0;
        end
        OP_ALU: begin
          flags[BIT_V] <= alu_v;
          flags[BIT_N] <= alu_n;
          flags[BIT_Z] <= alu_z;
          flags[BIT_C] <= alu_c;
          if (alu_h_upd) begin
            flags[BIT_H] <= alu_h;
          end
        end
        OP_CARRY_LOAD:           flags[BIT_C] <= op.data8[0];
        OP_CLEAR_MASK:           flags[BIT_I] <= 1'b0;
        OP_SET_MASK:             flags[BIT_I] <= 1'b1;
        OP_WAIT, OP_STOP:        flags[BIT_I] <= 1'b0;
        default:                 flags <= flags | FLAGS_ONES;
      endcase
    end else if (apb_wr && (paddr == OFS_FLAGS)) begin
      // software may set the mask here but never clear it
      flags <= pwdata[7:0] | FLAGS_ONES | {4'h0, flags[BIT_I], 3'h0};
    end
  end

  // ****************************************
  // vectors, break and core outputs
  // ****************************************
  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      vec_addr   <= VEC_RESET;
      brk_active <= 1'b0;
      instr_reg  <= 8'h00;
      ea         <= 16'h0000;
      op_ready   <= 1'b0;
      core_run   <= 1'b0;
      flags_out  <= FLAGS_RESET;
    end else begin
      if (take_brk) begin
        vec_addr   <= monitor_mode ? VEC_BREAK_MON : VEC_BREAK;
        instr_reg  <= SWI_OPCODE;
        brk_active <= 1'b1;
      end else if (take_irq || (state == ST_WAIT) || (state == ST_STOP)) begin
        vec_addr <= irq_vector;
      end else if ((state == ST_PULL) && mem_fin && (cnt == STK_LAST)
                   && brk_active && !brk_req) begin
        brk_active <= 1'b0;
      end
      if (op_fire && (op.base != BASE_NONE)) begin
        ea <= next_ea;
      end
      op_ready  <= (state == ST_RUN);
      // clock gate of the core is off in wait, stop and the stab settling count, on in every other state
      core_run  <= (state != ST_WAIT) && (state != ST_STOP)
                   && (state != ST_STAB);
      flags_out <= flags | FLAGS_ONES;
    end
  end

  // ****************************************
  // apb slave
  // ****************************************
  always_comb begin
    rd_hit = 1'b1;
    case (paddr)
      OFS_ACC:    rd_val = {24'h000000, acc};
      OFS_PTR:    rd_val = {16'h0000, ptr};
      OFS_SP:     rd_val = {16'h0000, sp};
      OFS_PC:     rd_val = {16'h0000, pc};
      OFS_FLAGS:  rd_val = {24'h000000, flags | FLAGS_ONES};
      OFS_STATUS: rd_val = {16'h0000, instr_reg, 4'h0, (state == ST_STOP),
                            (state == ST_WAIT), brk_active, core_run};
      default: begin
        rd_val = 32'h00000000;
        rd_hit = 1'b0;
      end
    endcase
  end

  // one setup cycle then a single access cycle, no extra wait states
  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      pready  <= 1'b0;
      prdata  <= 32'h00000000;
      pslverr <= 1'b0;
    end else if (psel && !penable) begin
      pready  <= 1'b1;
      prdata  <= pwrite ? 32'h00000000 : rd_val;
      pslverr <= !rd_hit;
    end else begin
      pready  <= 1'b0;
      pslverr <= 1'b0;
    end
  end

endmodule

//--- bench/crs_mem_model.sv
// memory partner that answers core requests after a random delay
`timescale 1ns/10ps
module crs_mem_model (
  // clock
  input  wire logic                     sys_clk,
  // request and answer
  input  wire crs_pkg::crs_mem_req_type mem_out,
  output logic                          mem_ack,
  output logic [7:0]                    mem_rdata
);
  import crs_pkg::*;
  logic [7:0] mem [0:65535];
  int         seed = 46592;
  int         dly  = 0;
  initial begin
    mem_ack   = 1'b0;
    mem_rdata = 8'h00;
  end
  // data line toggles when not answering, so stale reads never look right
  always @(posedge sys_clk) begin
    mem_ack   <= 1'b0;
    mem_rdata <= ~mem_rdata;
    if (mem_out.req && !mem_ack) begin
      if (dly == 0) begin
        mem_ack <= 1'b1;
        dly = $unsigned($random(seed)) % 3;
        if (mem_out.write)
          mem[mem_out.addr] = mem_out.wdata;
        else
          mem_rdata <= mem[mem_out.addr];
      end else
        dly = dly - 1;
    end
  end
endmodule

//--- bench/crs_core_regs_asserts.sv
// port checks for the core register state
`timescale 1ns/10ps
module crs_core_regs_asserts
  import crs_pkg::*;
(
  // clock and reset
  input wire logic                     sys_clk,
  input wire logic                     sys_rst,
  // watched ports
  input wire logic                     psel,
  input wire logic                     penable,
  input wire logic [7:0]               paddr,
  input wire logic                     pready,
  input wire logic                     pslverr,
  input wire logic [7:0]               flags_out,
  input wire logic [7:0]               instr_reg,
  input wire logic                     core_run,
  input wire logic                     brk_req,
  input wire logic                     brk_active,
  input wire logic                     mem_ack,
  input wire crs_pkg::crs_mem_req_type mem_out
);
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (sys_rst);
  sequence setup_s;
    psel && !penable;
  endsequence
  chk_flags_ones: assert property (flags_out[6:5] == 2'b11)
    else $error("flag bits six and five not one");
  chk_reset_flags: assert property ($fell(sys_rst) |-> flags_out == FLAGS_RESET)
    else $error("flags wrong after reset");
  chk_reset_fetch: assert property ($fell(sys_rst) |-> ##[0:2]
    (mem_out.req && mem_out.addr == VEC_RESET)) else $error("no reset vector fetch");
  chk_req_hold: assert property (mem_out.req && !mem_ack |=>
    mem_out.req && $stable(mem_out.addr)) else $error("memory request dropped");
  chk_apb_ready: assert property (setup_s |=> pready)
    else $error("no ready in access cycle");
  chk_apb_error: assert property (setup_s ##0 (paddr > OFS_STATUS) |=> pslverr)
    else $error("unmapped access not refused");
  chk_break_opc: assert property ($rose(brk_active) |-> ##[0:1]
    instr_reg == SWI_OPCODE) else $error("break opcode missing");
  chk_wait_mask: assert property ($fell(core_run) |-> ##[0:2] !flags_out[BIT_I])
    else $error("mask set in low power");
  chk_brk_hold: assert property (brk_active && brk_req |=> brk_active)
    else $error("break ended while requested");
endmodule

//--- bench/tb.sv
// self-checking bench for the core register state
`timescale 1ns/10ps
module tb;
  import crs_pkg::*;
  // ****************************************
  // signals
  // ****************************************
  logic            sys_clk, sys_rst, op_valid, instr_end, irq_req, brk_req;
  logic            brk_match_last, monitor_mode, psel, penable, pwrite, pready;
  logic            pslverr, op_ready, core_run, brk_active, mem_ack, re;
  logic [7:0]      paddr, flags_out, instr_reg, mem_rdata, a, m;
  logic [31:0]     pwdata, prdata, rv;
  logic [15:0]     irq_vector, ea;
  crs_op_type      op;
  crs_mem_req_type mem_out;
  int              miscompares = 0;
  int              n_compared  = 0;
  int              seed        = 46592;
  int              s, fl;
  crs_alu_kind_type alu_k      = ALU_ADD;
  crs_core_regs dut_u (.*);
  crs_mem_model mem_u (.*);
  // ****************************************
  // tasks
  // ****************************************
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_compared++;
    if (got !== exp) begin
      miscompares++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic wt(ref logic sig, input logic v);
    int t;
    t = 0;
    while (sig !== v && t < 5000) begin
      @(posedge sys_clk);
      t++;
    end
    if (t == 5000) miscompares++;
  endtask
  task automatic apb(input logic w, input logic [7:0] ad, input logic [31:0] d);
    @(posedge sys_clk);
    psel    <= 1'b1;
    pwrite  <= w;
    paddr   <= ad;
    pwdata  <= d;
    @(posedge sys_clk);
    penable <= 1'b1;
    @(posedge sys_clk);
    wt(pready, 1'b1);
    rv = prdata;
    re = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] ad, input logic [31:0] exp);
    apb(1'b0, ad, 32'h0);
    chk(rv, exp);
  endtask
  // an op may start a memory step, so wait until the core is back in run
  task automatic settle();
    repeat (3) @(posedge sys_clk);
    wt(op_ready, 1'b1);
  endtask
  task automatic do_op(input crs_op_kind_type k, input logic [7:0] d8,
                       input crs_base_type b, input logic [15:0] d16);
    @(posedge sys_clk);
    op_valid <= 1'b1;
    op       <= '{k, alu_k, b, d8, d16};
    @(posedge sys_clk);
    op_valid <= 1'b0;
    settle();
  endtask
  task automatic conclude();
    $display("compared %0d mismatched %0d", n_compared, miscompares);
    if (miscompares == 0 && n_compared > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask
  // ****************************************
  // clock, watchdog, tests
  // ****************************************
  initial begin
    sys_clk = 1'b0;
    forever #25 sys_clk = ~sys_clk;
  end
  initial begin
    repeat (20000) @(posedge sys_clk);
    miscompares++;
    conclude();
  end
  initial begin
    sys_rst = 1'b1;
    {op_valid, psel, penable, pwrite, irq_req, brk_req, brk_match_last, monitor_mode} = '0;
    instr_end  = 1'b1;
    op         = '0;
    paddr      = 8'h00;
    pwdata     = 32'h0;
    irq_vector = 16'hfff8;
    mem_u.mem[VEC_RESET]     = 8'h12;
    mem_u.mem[VEC_RESET + 1] = 8'h34;
    mem_u.mem[16'hfff8]      = 8'h40;
    mem_u.mem[16'hfff9]      = 8'h00;
    mem_u.mem[VEC_BREAK]     = 8'h50;
    mem_u.mem[VEC_BREAK + 1] = 8'h00;
    mem_u.mem[VEC_BREAK_MON]     = 8'h60;
    mem_u.mem[VEC_BREAK_MON + 1] = 8'h00;
    repeat (2) @(posedge sys_clk);
    sys_rst <= 1'b0;
    settle();
    rd(OFS_PC, 32'h1234);
    rd(OFS_SP, 32'h00ff);
    rd(OFS_FLAGS, 32'h68);
    apb(1'b0, 8'h40, 32'h0);
    chk(re, 1'b1);
    for (int i = 0; i < 16; i++) begin
      a = 8'($random(seed));
      m = 8'($random(seed));
      do_op(OP_LOAD_ACC, a, BASE_NONE, 16'h0);
      do_op(OP_ALU, m, BASE_NONE, 16'h0);
      s  = int'(a) + int'(m);
      fl = 'h68 | s[7] << BIT_N | (s[7:0] == 0) << BIT_Z | s[8] << BIT_C;
      fl = fl | ((a[7] == m[7]) && (s[7] != a[7])) << BIT_V;
      fl = fl | ((a[3:0] + m[3:0]) > 15) << BIT_H;
      rd(OFS_ACC, s & 'hff);
      rd(OFS_FLAGS, fl);
      chk(flags_out, fl);
    end
    do_op(OP_LOAD_ACC, 8'h0f, BASE_NONE, 16'h0);
    do_op(OP_CARRY_LOAD, 8'h01, BASE_NONE, 16'h0);
    alu_k = ALU_ADC;
    do_op(OP_ALU, 8'h01, BASE_NONE, 16'h0);
    rd(OFS_FLAGS, 32'h78);
    alu_k = ALU_SUB;
    do_op(OP_ALU, 8'h12, BASE_NONE, 16'h0);
    alu_k = ALU_ADD;
    rd(OFS_ACC, 32'hff);
    rd(OFS_FLAGS, 32'h7d);
    do_op(OP_PC_LOAD, 8'h0, BASE_NONE, 16'h2000);
    do_op(OP_PC_INC, 8'h0, BASE_NONE, 16'h0);
    rd(OFS_PC, 32'h2001);
    do_op(OP_LOAD_HIGH, 8'h5a, BASE_NONE, 16'h0);
    do_op(OP_LOAD_LOW, 8'h3c, BASE_NONE, 16'h0);
    do_op(OP_NOP, 8'h0, BASE_PTR, 16'h0010);
    rd(OFS_PTR, 32'h5a3c);
    chk(ea, 16'h5a4c);
    apb(1'b1, OFS_SP, 32'h0234);
    do_op(OP_STACK_RESET, 8'h0, BASE_NONE, 16'h0);
    rd(OFS_SP, 32'h02ff);
    do_op(OP_NOP, 8'h0, BASE_SP, 16'h0003);
    chk(ea, 16'h0302);
    do_op(OP_PUSH_HIGH, 8'h0, BASE_NONE, 16'h0);
    rd(OFS_SP, 32'h02fe);
    chk(mem_u.mem[16'h02ff], 8'h5a);
    mem_u.mem[16'h02ff] = 8'hc3;
    do_op(OP_PULL_HIGH, 8'h0, BASE_NONE, 16'h0);
    rd(OFS_SP, 32'h02ff);
    rd(OFS_PTR, 32'hc33c);
    irq_req <= 1'b1;
    rd(OFS_SP, 32'h02ff);
    do_op(OP_CLEAR_MASK, 8'h0, BASE_NONE, 16'h0);
    irq_req <= 1'b0;
    rd(OFS_SP, 32'h02fa);
    rd(OFS_PC, 32'h4000);
    chk(mem_u.mem[16'h02fd], 8'h3c);
    chk(mem_u.mem[16'h02fb][BIT_I], 1'b0);
    apb(1'b0, OFS_FLAGS, 32'h0);
    chk(rv[BIT_I], 1'b1);
    instr_end    <= 1'b0;
    monitor_mode <= 1'($random(seed));
    brk_req      <= 1'b1;
    repeat (4) @(posedge sys_clk);
    chk(brk_active, 1'b0);
    instr_end <= 1'b1;
    wt(brk_active, 1'b1);
    settle();
    chk(instr_reg, SWI_OPCODE);
    rd(OFS_STATUS, {16'h0000, SWI_OPCODE, 8'h03});
    rd(OFS_PC, monitor_mode ? 32'h6000 : 32'h5000);
    do_op(OP_RTI, 8'h0, BASE_NONE, 16'h0);
    chk(brk_active, 1'b1);
    brk_req <= 1'b0;
    do_op(OP_RTI, 8'h0, BASE_NONE, 16'h0);
    chk(brk_active, 1'b0);
    rd(OFS_PC, 32'h2001);
    fork
      begin
        wt(core_run, 1'b0);
        irq_req <= 1'b1;
      end
    join_none
    do_op(OP_WAIT, 8'h0, BASE_NONE, 16'h0);
    irq_req <= 1'b0;
    rd(OFS_PC, 32'h4000);
    chk(mem_u.mem[16'h02fb][BIT_I], 1'b0);
    // stop wake must sit out the oscillator settling time before stacking
    irq_req <= 1'b1;
    s = int'($time);
    do_op(OP_STOP, 8'h0, BASE_NONE, 16'h0);
    chk(int'($time) - s > STAB_CYCLES * 50, 1'b1);
    irq_req <= 1'b0;
    chk(mem_u.mem[16'h02f6][BIT_I], 1'b0);
    rd(OFS_PC, 32'h4000);
    conclude();
  end
endmodule
bind crs_core_regs crs_core_regs_asserts chk_u (.*);
